// ===== common/pma_pkg.sv
// Purpose: Shared constants and types for the programmable macrocell array
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes:   Fuse bit set means the array column is connected to the term

package pma_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int N_CELL = 8;
    localparam int N_IN = 8;
    localparam int PT_PER_CELL = 8;
    localparam int N_PT = N_CELL * PT_PER_CELL;
    localparam int N_SIG = N_IN + N_CELL;
    localparam int N_COL = 2 * N_SIG;
    localparam int PT_OE_IDX = PT_PER_CELL - 1;
    localparam int PT_SUM_IO = PT_PER_CELL - 1;
    localparam int MID_LO = 3;
    localparam int MID_HI = 4;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int AW = 12;
    localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [AW-1:0] ADDR_CFG = 12'h004;
    localparam logic [AW-1:0] ADDR_STAT = 12'h008;
    localparam logic [AW-1:0] ADDR_PINS = 12'h00c;
    localparam logic [3:0] FUSE_PAGE = 4'h1;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CFG_W = 2 + 2 * N_CELL;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RST = 18'h00000;
    localparam logic [N_COL-1:0] FUSE_RST = 32'h00000000;
    localparam logic [N_CELL-1:0] Q_RST = 8'h00;
    localparam logic [N_CELL-1:0] PIN_RST = 8'hff;
    localparam logic [N_CELL-1:0] OE_RST = 8'h00;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;

    // ----------------------------------------------------------------
    // Configuration word
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [N_CELL-1:0] cell_polarity_local;
        logic [N_CELL-1:0] cell_mode_local;
        logic family_emulation_global;
        logic register_permit_global;
    } pma_cfg_t;

    // Asynchronous pin group, sampled as one vector
    typedef struct packed {
        logic [N_CELL-1:0] io;
        logic oe_n;
        logic clk;
        logic [N_IN-1:0] din;
    } pma_pins_t;

endpackage

// ===== rtl/pma_array.sv
// Purpose: Sum-of-products logic array with eight configurable output cells
// Assumes: Pins asynchronous to I_CLK; fuse map and configuration loaded over APB
// Notes:   Pin outputs lag the array by the sync and output flop stages
//
// Decided for this implementation: the register offsets and the APB interface to the registers.

`timescale 1ns/1ps

// Behaviour
// - Eight cells, four selectable configurations each
// - Each cell ORs at most eight terms
// - Array sees true and complement inputs
// - Empty term high, contradictory term low
// - Registers allowed: clock and enable pins shared
// - Registered cell enabled only by enable pin
// - Combinatorial enable by term or always; input off
// - Input cell uses adjacent pin; ends special
// - Two global bits, sixteen local bits
// - Register permit and family emulation globals
// - Mode bit picks configuration; polarity separate
// - Four muxes; end cells use inverted permit
// - Registered mode: 0,1,0 with eight terms
// - Flip-flop captures polarised sum on clock rise
// - Registered feedback from inverted flip-flop
// - Dedicated output feeds back except middle cells
// - Non-registered: clock, enable pins via end cells
// - Non-registered I/O: seven terms, eighth enables
// - Registered-device I/O: seven terms, own pin back
// - Input mode 1,0,1 with buffer disabled
// - Polarity xor: one high, zero low; registered pins come out one low, zero high
// - Flip-flops reset low, registered pins read high
module pma_array
    import pma_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [AW-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [N_IN-1:0] I_DIN,
    input wire logic I_PIN_CLK,
    input wire logic I_PIN_OE_N,
    input wire logic [N_CELL-1:0] I_IO,
    output logic [N_CELL-1:0] O_IO,
    output logic [N_CELL-1:0] O_IO_OE
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pma_pins_t pins_in;
    pma_pins_t sync1_r;
    pma_pins_t sync2_r;
    logic pin_clk_d_r;
    logic [2:0] arm_r;
    logic clk_rise;

    assign pins_in = '{io: I_IO, oe_n: I_PIN_OE_N, clk: I_PIN_CLK, din: I_DIN};

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pin_clk_d_r <= 1'b0;
            arm_r <= '0;
        end else begin
            pin_clk_d_r <= sync2_r.clk;
            arm_r <= {arm_r[1:0], 1'b1};
        end
    end

    // No edge until the chain holds real samples: a pulled-up pin must not fake a rise
    assign clk_rise = sync2_r.clk & ~pin_clk_d_r & arm_r[2];

    // ----------------------------------------------------------------
    // Register file state
    // ----------------------------------------------------------------
    logic run_r;
    pma_cfg_t cfg_r;
    logic [N_COL-1:0] fuse_r [N_PT];
    logic [N_CELL-1:0] q_r;
    logic [N_CELL-1:0] o_io_r;
    logic [N_CELL-1:0] o_oe_r;

    logic perm;
    logic fam;
    assign perm = cfg_r.register_permit_global;
    assign fam = cfg_r.family_emulation_global;

    // ----------------------------------------------------------------
    // Product terms
    // ----------------------------------------------------------------
    logic [N_CELL-1:0] fb;
    logic [N_SIG-1:0] sig;
    logic [N_COL-1:0] col;
    logic [N_PT-1:0] pt;

    assign sig = {fb, sync2_r.din};

    always_comb begin
        for (int k = 0; k < N_SIG; k++) begin
            col[2*k] = sig[k];
            col[2*k+1] = ~sig[k];
        end
    end

    always_comb begin
        for (int p = 0; p < N_PT; p++) begin
            pt[p] = &(col | ~fuse_r[p]);
        end
    end

    // ----------------------------------------------------------------
    // Output cells
    // ----------------------------------------------------------------
    logic [N_CELL-1:0] reg_mode;
    logic [N_CELL-1:0] cio;
    logic [N_CELL-1:0] dout;
    logic [N_CELL-1:0] din_mode;
    logic [N_CELL-1:0] unsup;
    logic [N_CELL-1:0] sum;
    logic [N_CELL-1:0] comb_out;
    logic [N_CELL-1:0] adj;
    logic [N_CELL-1:0] fb_sel;
    logic [N_CELL-1:0] pin_nxt;
    logic [N_CELL-1:0] oe_nxt;

    for (genvar i = 0; i < N_CELL; i++) begin : g_cell
        logic ml;
        assign ml = cfg_r.cell_mode_local[i];

        // Mode decode from the three selecting bits
        assign reg_mode[i] = ~perm & fam & ~ml;
        assign cio[i] = fam & ml;
        assign dout[i] = perm & ~fam & ~ml;
        assign din_mode[i] = perm & ~fam & ml;
        assign unsup[i] = ~(reg_mode[i] | cio[i] | dout[i] | din_mode[i]);

        // Product-term mux: seven terms in I/O modes, else eight
        assign sum[i] = cio[i] ? (|pt[i*PT_PER_CELL +: PT_SUM_IO])
                               : (|pt[i*PT_PER_CELL +: PT_PER_CELL]);
        assign comb_out[i] = sum[i] ^ ~cfg_r.cell_polarity_local[i];

        // Adjacent pin path
        if (i == 0) begin : g_adj_first
            assign adj[i] = sync2_r.oe_n;
        end else if (i == N_CELL - 1) begin : g_adj_last
            assign adj[i] = sync2_r.clk;
        end else begin : g_adj_mid
            localparam int ADJ = (i < N_CELL / 2) ? i - 1 : i + 1;
            assign adj[i] = sync2_r.io[ADJ];
        end

        // Feedback select, end cells steered by inverted permit
        if (i == 0 || i == N_CELL - 1) begin : g_fsel_end
            assign fb_sel[i] = ~perm;
        end else begin : g_fsel_mid
            assign fb_sel[i] = fam;
        end

        always_comb begin
            if (fb_sel[i]) begin
                fb[i] = ml ? sync2_r.io[i] : ~q_r[i];
            end else if (dout[i] && (i == MID_LO || i == MID_HI)) begin
                fb[i] = 1'b0;
            end else begin
                fb[i] = adj[i];
            end
        end

        // Pin value and enable select
        assign pin_nxt[i] = reg_mode[i] ? ~q_r[i] : comb_out[i];
        always_comb begin
            if (!run_r || unsup[i]) begin
                oe_nxt[i] = 1'b0;
            end else if (reg_mode[i]) begin
                oe_nxt[i] = ~sync2_r.oe_n;
            end else if (cio[i]) begin
                oe_nxt[i] = pt[i*PT_PER_CELL + PT_OE_IDX];
            end else begin
                oe_nxt[i] = dout[i];
            end
        end

        // ------------------------------------------------------------
        // Cell checks
        // ------------------------------------------------------------
        sequence s_reg_edge;
            clk_rise && reg_mode[i];
        endsequence

        a_reg_capture: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            s_reg_edge |=> (q_r[i] == $past(comb_out[i])))
            else $error("cell flip-flop missed the clock rise");

        a_reg_feedback: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            reg_mode[i] |-> (fb[i] == ~q_r[i]))
            else $error("registered feedback not from inverted flip-flop");

        a_reg_oe_pin: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            (run_r && reg_mode[i]) |=> (O_IO_OE[i] == ~$past(sync2_r.oe_n)))
            else $error("registered enable not following enable pin");

        a_input_off: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            din_mode[i] |=> !O_IO_OE[i])
            else $error("input cell drives its pin");

        a_dout_drive: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            (run_r && dout[i]) [*2] |-> (O_IO_OE[i] && O_IO[i] == $past(comb_out[i])))
            else $error("dedicated output not driven");

        a_cio_enable: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            (run_r && cio[i]) |=> (O_IO_OE[i] == $past(pt[i*PT_PER_CELL + PT_OE_IDX])))
            else $error("I/O enable not from the eighth term");

        a_pol_xor: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
            (dout[i] && cfg_r.cell_polarity_local[i]) |=> (O_IO[i] == $past(sum[i])))
            else $error("active-high polarity inverted");

        if (i == MID_LO || i == MID_HI) begin : g_mid_chk
            a_mid_nofb: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
                dout[i] |-> (fb[i] == 1'b0))
                else $error("middle cell feeds back in dedicated output");
        end
    end

    // ----------------------------------------------------------------
    // Cell flip-flops and pin output flops
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            q_r <= Q_RST;
        end else if (clk_rise && !perm) begin
            q_r <= comb_out;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            o_io_r <= PIN_RST;
            o_oe_r <= OE_RST;
        end else begin
            o_io_r <= pin_nxt;
            o_oe_r <= oe_nxt;
        end
    end

    assign O_IO = o_io_r;
    assign O_IO_OE = o_oe_r;

    // ----------------------------------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------------------------------
    logic setup;
    logic access;
    logic is_fuse;
    logic [5:0] fuse_idx;
    logic hit_err;
    logic [31:0] rd_nxt;
    logic wr_ok_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    assign setup = I_PSEL & ~I_PENABLE;
    assign access = I_PSEL & I_PENABLE & pready_r;
    assign is_fuse = (I_PADDR[AW-1:8] == FUSE_PAGE);
    assign fuse_idx = I_PADDR[7:2];

    always_comb begin
        rd_nxt = DATA_ZERO;
        hit_err = 1'b0;
        if (I_PADDR[1:0] != 2'b00) begin
            hit_err = 1'b1;
        end else if (is_fuse) begin
            rd_nxt = fuse_r[fuse_idx];
            hit_err = I_PWRITE & run_r;
        end else begin
            case (I_PADDR)
                ADDR_CTRL: rd_nxt[CTRL_RUN_BIT] = run_r;
                ADDR_CFG: begin
                    rd_nxt[CFG_W-1:0] = cfg_r;
                    hit_err = I_PWRITE & run_r;
                end
                ADDR_STAT: begin
                    rd_nxt[N_CELL-1:0] = unsup;
                    rd_nxt[2*N_CELL-1:N_CELL] = reg_mode;
                    rd_nxt[3*N_CELL-1:2*N_CELL] = q_r;
                    hit_err = I_PWRITE;
                end
                ADDR_PINS: begin
                    rd_nxt[N_CELL-1:0] = sync2_r.io;
                    rd_nxt[2*N_CELL-1:N_CELL] = o_oe_r;
                    hit_err = I_PWRITE;
                end
                default: hit_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= DATA_ZERO;
            wr_ok_r <= 1'b0;
        end else if (setup) begin
            pready_r <= 1'b1;
            pslverr_r <= hit_err;
            prdata_r <= (I_PWRITE || hit_err) ? DATA_ZERO : rd_nxt;
            wr_ok_r <= I_PWRITE & ~hit_err;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= DATA_ZERO;
            wr_ok_r <= 1'b0;
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PREADY = pready_r;
    assign O_PSLVERR = pslverr_r;

    // Register writes at the access edge
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            run_r <= 1'b0;
        end else if (access && wr_ok_r && I_PADDR == ADDR_CTRL) begin
            run_r <= I_PWDATA[CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg_r <= CFG_RST;
        end else if (access && wr_ok_r && I_PADDR == ADDR_CFG) begin
            cfg_r <= I_PWDATA[CFG_W-1:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            for (int p = 0; p < N_PT; p++) begin
                fuse_r[p] <= FUSE_RST;
            end
        end else if (access && wr_ok_r && is_fuse) begin
            fuse_r[fuse_idx] <= I_PWDATA;
        end
    end

    // ----------------------------------------------------------------
    // Global checks
    // ----------------------------------------------------------------
    logic rst_done_r;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_done_r <= 1'b0;
        end else begin
            rst_done_r <= 1'b1;
        end
    end

    a_reset_low: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        !rst_done_r |-> (q_r == Q_RST && O_IO == PIN_RST))
        else $error("flip-flops or registered pins wrong after reset");

    a_cfg_locked: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (run_r && $past(run_r)) |-> $stable(cfg_r))
        else $error("configuration changed while running");

    a_term_contra: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (fuse_r[1][1:0] == 2'b11) |-> !pt[1])
        else $error("contradictory term not low");

    a_term_empty: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
        (fuse_r[1] == FUSE_RST) |-> pt[1])
        else $error("empty term not high");

endmodule

// ===== tb/pma_board.sv
// Purpose: Board model around the array pins
// Assumes: Every I/O pad has a pull-up on the board
// Notes:   A released pad reads high, never the last driven value

`timescale 1ns/1ps

module pma_board
    import pma_pkg::*;
(
    input wire pma_pins_t i_drv,
    input wire logic [N_CELL-1:0] i_drv_en,
    input wire logic [N_CELL-1:0] i_dev_io,
    input wire logic [N_CELL-1:0] i_dev_oe,
    output pma_pins_t o_pad
);
    // ----------------------------------------------------------------
    // Pad resolution
    // ----------------------------------------------------------------
    always_comb begin
        o_pad = i_drv;
        for (int c = 0; c < N_CELL; c++) begin
            if (i_dev_oe[c]) begin
                o_pad.io[c] = i_dev_io[c];
            end else if (i_drv_en[c]) begin
                o_pad.io[c] = i_drv.io[c];
            end else begin
                o_pad.io[c] = 1'b1;
            end
        end
    end
endmodule

// ===== tb/pma_array_tb.sv
// Purpose: Self-checking bench for the macrocell array
// Assumes: Zero-wait APB slave, pin effects within six clocks
// Notes:   Each cell uses one random product term, other terms contradictory

`timescale 1ns/1ps

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module pma_array_tb;
    import pma_pkg::*;
    logic clk, rstn, psel, pen, pwr, er;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr;
    pma_pins_t drv, pad;
    logic [N_CELL-1:0] drv_en, o_io, o_oe, m, pol, neg, d;
    logic [2:0] k [N_CELL];
    int n_mismatch, n_tests;

    pma_array i_pma_array (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_DIN(pad.din), .I_PIN_CLK(pad.clk), .I_PIN_OE_N(pad.oe_n), .I_IO(pad.io), .O_IO(o_io),
        .O_IO_OE(o_oe));
    pma_board i_pma_board (.i_drv(drv), .i_drv_en(drv_en), .i_dev_io(o_io), .i_dev_oe(o_oe), .o_pad(pad));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic setup(input logic perm, input logic fam, input logic [7:0] md);
        apb(1'b1, ADDR_CTRL, 32'h00000000);
        apb(1'b1, ADDR_CFG, {14'h0000, pol, md, fam, perm});
        apb(1'b1, ADDR_CTRL, 32'h00000001);
    endtask

    task automatic pins(input logic [7:0] dv);
        drv.din <= dv;
        repeat (6) @(posedge clk);
    endtask

    task automatic term7(input logic [31:0] ev, input logic [31:0] od);
        // Fuses are locked while running
        apb(1'b1, ADDR_CTRL, 32'h00000000);
        for (int c = 0; c < N_CELL; c++) begin
            apb(1'b1, 12'(256 + 4 * (c * 8 + 7)), c[0] ? od : ev);
        end
    endtask

    function automatic logic [7:0] calc(input logic [7:0] dv);
        logic [7:0] r;
        for (int c = 0; c < N_CELL; c++) begin
            r[c] = (dv[k[c]] ^ neg[c]) ^ ~pol[c];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100us;
        n_mismatch++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {psel, pen, pwr} = 3'h0;
        paddr = '0;
        pwdata = '0;
        drv = '0;
        drv.oe_n = 1'b0;
        drv_en = '0;
        n_mismatch = 0;
        n_tests = 0;
        void'($urandom(75235));
        repeat (10) @(posedge clk);
        `CHK(o_io, PIN_RST);
        `CHK(o_oe, OE_RST);
        rstn <= 1'b1;
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK({er, rd}, {1'b1, DATA_ZERO});
        apb(1'b1, ADDR_STAT, 32'hffffffff);
        `CHK(er, 1'b1);
        pol = 8'($urandom);
        neg = 8'($urandom);
        for (int c = 0; c < N_CELL; c++) begin
            k[c] = 3'($urandom_range(7));
        end
        for (int p = 0; p < N_PT; p++) begin
            apb(1'b1, 12'(256 + 4 * p), (p % 8 == 0) ? 32'h1 << (2 * k[p / 8] + neg[p / 8]) : 32'h3);
        end
        // Combinatorial outputs mixed with dedicated inputs
        m = 8'($urandom);
        setup(1'b1, 1'b0, m);
        apb(1'b0, ADDR_CFG, 32'h00000000);
        `CHK(rd, {14'h0000, pol, m, 2'b01});
        apb(1'b1, ADDR_CFG, 32'h00000000);
        `CHK(er, 1'b1);
        repeat (8) begin
            d = 8'($urandom);
            pins(d);
            `CHK(o_oe, ~m);
            `CHK(o_io & ~m, calc(d) & ~m);
        end
        // Combinatorial I/O, enable term empty on even cells only
        term7(32'h0, 32'h3);
        for (int g = 1; g >= 0; g--) begin
            setup(g[0], 1'b1, 8'hff);
            repeat (4) begin
                d = 8'($urandom);
                pins(d);
                `CHK(o_oe, 8'h55);
                `CHK(o_io & 8'h55, calc(d) & 8'h55);
            end
        end
        // Registered outputs
        term7(32'h3, 32'h3);
        setup(1'b0, 1'b1, 8'h00);
        pins(8'h00);
        `CHK(o_io, 8'hff);
        `CHK(o_oe, 8'hff);
        drv.oe_n <= 1'b1;
        pins(8'h00);
        `CHK(o_oe, 8'h00);
        drv.oe_n <= 1'b0;
        repeat (4) begin
            d = 8'($urandom);
            pins(d);
            drv.clk <= 1'b1;
            pins(d);
            drv.clk <= 1'b0;
            pins(~d);
            `CHK(o_io, ~calc(d));
            apb(1'b0, ADDR_STAT, 32'h00000000);
            `CHK(rd[23:8], {calc(d), 8'hff});
        end
        // Unsupported combination
        setup(1'b0, 1'b0, 8'h0f);
        pins(8'h00);
        `CHK(o_oe, 8'h00);
        apb(1'b0, ADDR_STAT, 32'h00000000);
        `CHK(rd[7:0], 8'hff);
        stop_test();
    end
endmodule
